// *** core/mcdac_fifo.sv ***
// module: command word fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module mcdac_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  mcdac_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wr_ptr_ff;
  logic [AW:0]   rd_ptr_ff;
  logic [W-1:0]  out_data_ff;
  logic          out_valid_ff;
  logic [AW:0]   count;
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;
  assign count = wr_ptr_ff - rd_ptr_ff;
  assign full  = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  // output register refills whenever it is empty or being taken
  assign pop   = !empty && (!out_valid_ff || port.out_ready);
  assign push  = port.in_valid && !full;
  assign port.in_ready  = !full;
  assign port.out_valid = out_valid_ff;
  assign port.out_data  = out_data_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= port.in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) begin
        rd_ptr_ff   <= rd_ptr_ff + 1'b1;
        out_data_ff <= mem[rd_ptr_ff[AW-1:0]];
      end
      if (pop) out_valid_ff <= 1'b1;
      else if (port.out_ready) out_valid_ff <= 1'b0;
    end
  end
endmodule // mcdac_fifo
`default_nettype wire

// *** core/mcdac_fifo_if.sv ***
// interface: valid/ready word path between the block and its fifo
`timescale 1ns/1ps
`default_nettype none
interface mcdac_fifo_if #(parameter int W = 19);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** core/mcdac_pkg.sv ***
// package: constants for the motion clock and dac output block
package mcdac_pkg;
  localparam int unsigned CLK_FREQ_100HZ  = 1250000;  // 125 MHz system clock
  localparam int unsigned BASE_FREQ_100HZ = 1179648;  // 117,964.8 kHz divider base
  localparam int unsigned HW_FREQ_100HZ   = 393216;   // 39.3216 MHz hardware clock source
  localparam int unsigned SERVO_FREQ_100HZ = 23;      // default servo rate, about 2.25 kHz
  localparam int          NCO_W           = 21;
  localparam int          NUM_CHAN        = 8;
  localparam int          NUM_GROUP       = 2;
  localparam int          STROBE_W        = 24;
  localparam int          DAC_W           = 16;
  localparam int          DIV_W           = 16;
  localparam int          HWCNT_W         = 7;
  localparam int          ADDR_W          = 20;
  // hardware clock select field positions, each a 3-bit power-of-two divider
  localparam int          HW_SCLK_LSB     = 0;
  localparam int          HW_PFM_LSB      = 3;
  localparam int          HW_DAC_LSB      = 6;
  localparam int          HW_ADC_LSB      = 9;
  localparam int          HW_SEL_W        = 12;
  // reset values
  localparam logic [DIV_W-1:0]    TOP_DIV_RST    = 16'h197f;
  localparam logic [3:0]          PHASE_DIV_RST  = 4'h0;
  localparam logic [3:0]          SERVO_DIV_RST  = 4'h3;
  localparam logic [HW_SEL_W-1:0] HW_SEL_RST     = 12'h6c2;
  localparam logic [STROBE_W-1:0] STROBE_RST     = 24'h7fffc0;
  // encoder decode and output mode codes
  localparam logic [3:0] DEC_X4_CW  = 4'h3;
  localparam logic [3:0] DEC_X4_CCW = 4'h7;
  localparam logic [1:0] OMODE_DAC_PWM = 2'h1;
  localparam logic [1:0] OMODE_DAC_PFM = 2'h3;
  // command target addresses
  localparam logic [ADDR_W-1:0] DAC_A_BASE   = 20'h0c002;
  localparam logic [ADDR_W-1:0] DAC_A_STEP   = 20'h00008;
  localparam logic [ADDR_W-1:0] RING1_BASE   = 20'h0c0a3;
  localparam logic [ADDR_W-1:0] RING1_BANK   = 20'h80000;
  localparam logic [ADDR_W-1:0] RINGM_BASE   = 20'h0c0a0;
  localparam logic [ADDR_W-1:0] NODE_STEP    = 20'h00004;
  typedef enum logic [1:0] {
    MCDAC_TGT_DAC   = 2'h0,
    MCDAC_TGT_RING1 = 2'h1,
    MCDAC_TGT_RINGM = 2'h3
  } mcdac_tgt_e;
  typedef enum logic {
    MCDAC_SER_IDLE  = 1'b0,
    MCDAC_SER_SHIFT = 1'b1
  } mcdac_ser_e;
endpackage

// *** core/mcdac_top.sv ***
// module: motion clock chain, strobe words, channel and motor output setup
`timescale 1ns/1ps
`default_nettype none
module mcdac_top #(
  parameter int NCHAN = mcdac_pkg::NUM_CHAN,
  parameter int DEPTH = 16
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic [mcdac_pkg::DIV_W-1:0]           top_phase_divider,
  input  wire logic [3:0]                            phase_divider,
  input  wire logic [3:0]                            servo_divider,
  input  wire logic [mcdac_pkg::HW_SEL_W-1:0]        hw_clock_select_low_group,
  input  wire logic [mcdac_pkg::HW_SEL_W-1:0]        hw_clock_select_high_group,
  input  wire logic [mcdac_pkg::STROBE_W-1:0]        strobe_word_low_group,
  input  wire logic [mcdac_pkg::STROBE_W-1:0]        strobe_word_high_group,
  input  wire logic [NCHAN*4-1:0]                    encoder_decode_select,
  input  wire logic [NCHAN*2-1:0]                    output_mode_select,
  input  wire logic [NCHAN-1:0]                      output_invert_select,
  input  wire logic [NCHAN-1:0]                      motor_activate,
  input  wire logic [NCHAN-1:0]                      commutation_select,
  input  wire logic [NCHAN*2-1:0]                    target_kind_select,
  input  wire logic                                  cmd_valid,
  output logic                                       cmd_ready,
  input  wire logic [2:0]                            cmd_chan,
  input  wire logic [mcdac_pkg::DAC_W-1:0]           cmd_value,
  output logic                                       top_phase_clock,
  output logic                                       pwm_cycle_tick,
  output logic                                       phase_tick,
  output logic                                       servo_tick,
  output logic [NCHAN-1:0]                           motor_run,
  output logic [NCHAN-1:0]                           single_output,
  output logic [NCHAN*mcdac_pkg::ADDR_W-1:0]         command_output_target,
  output logic [NCHAN-1:0]                           quad_x4,
  output logic [NCHAN-1:0]                           count_reverse,
  output logic [NCHAN-1:0]                           ab_dac_mode,
  output logic [NCHAN-1:0]                           c_pwm_mode,
  output logic [NCHAN-1:0]                           c_pfm_mode,
  output logic [mcdac_pkg::NUM_GROUP-1:0]            enc_sample_tick,
  output logic [mcdac_pkg::NUM_GROUP-1:0]            pulse_freq_mod_clock,
  output logic [mcdac_pkg::NUM_GROUP-1:0]            dac_bit_tick,
  output logic [mcdac_pkg::NUM_GROUP-1:0]            adc_tick,
  output logic [mcdac_pkg::NUM_GROUP-1:0]            dac_strobe,
  output logic [NCHAN-1:0]                           dac_data
);
  localparam int NG  = mcdac_pkg::NUM_GROUP;
  localparam int SW  = mcdac_pkg::STROBE_W;
  localparam int DW  = mcdac_pkg::DAC_W;
  localparam int NW  = mcdac_pkg::NCO_W;
  localparam int HW  = mcdac_pkg::HWCNT_W;
  localparam int AW  = mcdac_pkg::ADDR_W;
  localparam int FW  = DW + 3;
  localparam logic [NW-1:0] NCO_MOD  = NW'(mcdac_pkg::CLK_FREQ_100HZ);
  localparam logic [NW-1:0] BASE_INC = NW'(mcdac_pkg::BASE_FREQ_100HZ);
  localparam logic [NW-1:0] HW_INC   = NW'(mcdac_pkg::HW_FREQ_100HZ);

  ////////////////////////////////////////////////////////////////////////////////
  // decoding functions

  // tick of a 2^n divider: source tick with the low n count bits at zero
  function automatic logic pow2_tick(input logic [2:0] n, input logic [HW-1:0] cnt,
                                     input logic src);
    logic [HW-1:0] mask;
    mask = HW'((8'h01 << n) - 8'h01);
    return src && ((cnt & mask) == '0);
  endfunction

  // command address for motor index m under the chosen target kind
  function automatic logic [AW-1:0] target_addr(input logic [1:0] kind, input logic [2:0] m);
    logic [AW-1:0] idx;
    idx = AW'(m);
    case (kind)
      mcdac_pkg::MCDAC_TGT_RING1:
        return mcdac_pkg::RING1_BASE + mcdac_pkg::NODE_STEP * AW'(m[0])
               + AW'(4'h8) * AW'(m[2]) + (m[1] ? mcdac_pkg::RING1_BANK : '0);
      mcdac_pkg::MCDAC_TGT_RINGM:
        return mcdac_pkg::RINGM_BASE + mcdac_pkg::NODE_STEP * idx;
      default:
        return mcdac_pkg::DAC_A_BASE + mcdac_pkg::DAC_A_STEP * idx;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // rate generators from the 125 MHz clock

  logic [NW-1:0] base_acc_ff;
  logic [NW-1:0] hw_acc_ff;
  logic [NW:0]   base_sum;
  logic [NW:0]   hw_sum;
  logic          base_tick;
  logic          hw_src_tick;
  assign base_sum    = {1'b0, base_acc_ff} + {1'b0, BASE_INC};
  assign hw_sum      = {1'b0, hw_acc_ff} + {1'b0, HW_INC};
  assign base_tick   = (base_sum >= {1'b0, NCO_MOD});
  assign hw_src_tick = (hw_sum >= {1'b0, NCO_MOD});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_acc_ff <= '0;
      hw_acc_ff   <= '0;
    end else begin
      base_acc_ff <= base_tick ? NW'(base_sum - {1'b0, NCO_MOD}) : NW'(base_sum);
      hw_acc_ff   <= hw_src_tick ? NW'(hw_sum - {1'b0, NCO_MOD}) : NW'(hw_sum);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // top phase, phase and servo clock chain

  logic [mcdac_pkg::DIV_W-1:0] top_div_ff;
  logic [3:0]                  phase_div_ff;
  logic [3:0]                  servo_div_ff;
  logic [mcdac_pkg::DIV_W-1:0] top_cnt_ff;
  logic [3:0]                  phase_cnt_ff;
  logic [3:0]                  servo_cnt_ff;
  logic                        top_clk_ff;
  logic                        phase_tick_ff;
  logic                        servo_tick_ff;
  logic                        half_end;
  logic                        top_rise;
  logic                        phase_end;
  logic                        servo_end;

  assign half_end  = base_tick && (top_cnt_ff == top_div_ff);
  assign top_rise  = half_end && !top_clk_ff;
  assign phase_end = top_rise && (phase_cnt_ff == phase_div_ff);
  assign servo_end = phase_end && (servo_cnt_ff == servo_div_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      top_div_ff   <= mcdac_pkg::TOP_DIV_RST;
      phase_div_ff <= mcdac_pkg::PHASE_DIV_RST;
      servo_div_ff <= mcdac_pkg::SERVO_DIV_RST;
    end else if (top_rise) begin
      // new settings only at a full top phase period, so no clock gets a runt
      top_div_ff   <= top_phase_divider;
      phase_div_ff <= phase_divider;
      servo_div_ff <= servo_divider;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      top_cnt_ff    <= '0;
      top_clk_ff    <= 1'b0;
      phase_cnt_ff  <= '0;
      servo_cnt_ff  <= '0;
      phase_tick_ff <= 1'b0;
      servo_tick_ff <= 1'b0;
    end else begin
      if (half_end) begin
        top_cnt_ff <= '0;
        top_clk_ff <= !top_clk_ff;
      end else if (base_tick) begin
        top_cnt_ff <= top_cnt_ff + 1'b1;
      end
      if (top_rise) phase_cnt_ff <= phase_end ? 4'h0 : phase_cnt_ff + 4'h1;
      if (phase_end) servo_cnt_ff <= servo_end ? 4'h0 : servo_cnt_ff + 4'h1;
      phase_tick_ff <= phase_end;
      servo_tick_ff <= servo_end;
    end
  end

  assign top_phase_clock = top_clk_ff;
  assign pwm_cycle_tick  = top_rise;
  assign phase_tick      = phase_tick_ff;
  assign servo_tick      = servo_tick_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // per-group hardware clocks and dac strobe words

  logic [mcdac_pkg::HW_SEL_W-1:0] hw_sel   [NG];
  logic [SW-1:0]                  strobe_w [NG];
  assign hw_sel[0]   = hw_clock_select_low_group;
  assign hw_sel[1]   = hw_clock_select_high_group;
  assign strobe_w[0] = strobe_word_low_group;
  assign strobe_w[1] = strobe_word_high_group;

  for (genvar g = 0; g < NG; g++) begin : g_group
    logic [HW-1:0] hw_cnt_ff;
    logic [SW-1:0] strobe_sr_ff;
    logic [4:0]    strobe_left_ff;
    logic          sclk_t;
    logic          pfm_t;
    logic          dac_t;
    logic          adc_t;
    logic          strobe_bit_ff;
    assign sclk_t = pow2_tick(hw_sel[g][mcdac_pkg::HW_SCLK_LSB +: 3], hw_cnt_ff, hw_src_tick);
    assign pfm_t  = pow2_tick(hw_sel[g][mcdac_pkg::HW_PFM_LSB +: 3], hw_cnt_ff, hw_src_tick);
    assign dac_t  = pow2_tick(hw_sel[g][mcdac_pkg::HW_DAC_LSB +: 3], hw_cnt_ff, hw_src_tick);
    assign adc_t  = pow2_tick(hw_sel[g][mcdac_pkg::HW_ADC_LSB +: 3], hw_cnt_ff, hw_src_tick);

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        hw_cnt_ff      <= '0;
        strobe_sr_ff   <= '0;
        strobe_left_ff <= '0;
        strobe_bit_ff  <= 1'b0;
      end else begin
        if (hw_src_tick) hw_cnt_ff <= hw_cnt_ff + 1'b1;
        if (phase_end) begin
          strobe_sr_ff   <= strobe_w[g];
          strobe_left_ff <= 5'(SW);
        end else if (dac_t && strobe_left_ff != '0) begin
          strobe_sr_ff   <= {strobe_sr_ff[SW-2:0], 1'b0};
          strobe_left_ff <= strobe_left_ff - 5'h01;
        end
        strobe_bit_ff <= (strobe_left_ff != '0) && strobe_sr_ff[SW-1];
      end
    end

    assign enc_sample_tick[g]      = sclk_t;
    assign pulse_freq_mod_clock[g] = pfm_t;
    assign dac_bit_tick[g]         = dac_t;
    assign adc_tick[g]             = adc_t;
    assign dac_strobe[g]           = strobe_bit_ff;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel setup decode and per-motor processing

  for (genvar c = 0; c < NCHAN; c++) begin : g_chan
    logic [3:0] dec;
    logic [1:0] om;
    assign dec = encoder_decode_select[c*4 +: 4];
    assign om  = output_mode_select[c*2 +: 2];
    assign quad_x4[c]       = (dec == mcdac_pkg::DEC_X4_CW) || (dec == mcdac_pkg::DEC_X4_CCW);
    assign count_reverse[c] = (dec == mcdac_pkg::DEC_X4_CCW);
    assign ab_dac_mode[c]   = (om == mcdac_pkg::OMODE_DAC_PWM) || (om == mcdac_pkg::OMODE_DAC_PFM);
    assign c_pwm_mode[c]    = (om == mcdac_pkg::OMODE_DAC_PWM);
    assign c_pfm_mode[c]    = (om == mcdac_pkg::OMODE_DAC_PFM);
    assign single_output[c] = motor_activate[c] && !commutation_select[c];
  end

  logic [NCHAN-1:0]    motor_run_ff;
  logic [NCHAN*AW-1:0] target_ff;
  logic [NCHAN*AW-1:0] nxt_target;
  for (genvar m = 0; m < NCHAN; m++) begin : g_motor
    assign nxt_target[m*AW +: AW] = target_addr(target_kind_select[m*2 +: 2], 3'(m));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_run_ff <= '0;
      target_ff    <= '0;
    end else begin
      // only active motors run their loop, whatever their output mode
      motor_run_ff <= servo_end ? motor_activate : '0;
      target_ff    <= nxt_target;
    end
  end
  assign motor_run             = motor_run_ff;
  assign command_output_target = target_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // command word fifo and dac serializer

  mcdac_fifo_if #(.W(FW)) fq ();
  assign fq.in_valid = cmd_valid;
  assign fq.in_data  = {cmd_chan, cmd_value};
  assign cmd_ready   = fq.in_ready;

  mcdac_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
    .clk  (clk),
    .rst  (rst),
    .port (fq.fifo)
  );

  mcdac_pkg::mcdac_ser_e ser_st_ff;
  logic [DW-1:0]         ser_sr_ff;
  logic [2:0]            ser_chan_ff;
  logic [4:0]            ser_left_ff;
  logic [NCHAN-1:0]      dac_data_ff;
  logic                  ser_dac_t;
  logic                  take;
  // the serializer waits on the dac clock, so a burst of commands backs up the fifo
  assign ser_dac_t   = pow2_tick(ser_chan_ff[2] ? hw_sel[1][mcdac_pkg::HW_DAC_LSB +: 3]
                                                : hw_sel[0][mcdac_pkg::HW_DAC_LSB +: 3],
                                 ser_chan_ff[2] ? g_group[1].hw_cnt_ff : g_group[0].hw_cnt_ff,
                                 hw_src_tick);
  assign take         = (ser_st_ff == mcdac_pkg::MCDAC_SER_IDLE) && fq.out_valid;
  assign fq.out_ready = (ser_st_ff == mcdac_pkg::MCDAC_SER_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ser_st_ff   <= mcdac_pkg::MCDAC_SER_IDLE;
      ser_sr_ff   <= '0;
      ser_chan_ff <= '0;
      ser_left_ff <= '0;
    end else begin
      case (ser_st_ff)
        mcdac_pkg::MCDAC_SER_IDLE: begin
          if (take) begin
            ser_chan_ff <= fq.out_data[FW-1 -: 3];
            ser_sr_ff   <= fq.out_data[DW-1:0];
            ser_left_ff <= 5'(DW);
            ser_st_ff   <= mcdac_pkg::MCDAC_SER_SHIFT;
          end
        end
        mcdac_pkg::MCDAC_SER_SHIFT: begin
          if (ser_dac_t) begin
            ser_sr_ff   <= {ser_sr_ff[DW-2:0], 1'b0};
            ser_left_ff <= ser_left_ff - 5'h01;
            if (ser_left_ff == 5'h01) ser_st_ff <= mcdac_pkg::MCDAC_SER_IDLE;
          end
        end
        default: ser_st_ff <= mcdac_pkg::MCDAC_SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_data_ff <= '0;
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        // idle lines sit at the inverted zero level so polarity holds between words
        dac_data_ff[i] <= ((ser_st_ff == mcdac_pkg::MCDAC_SER_SHIFT) && (ser_chan_ff == 3'(i))
                           && ser_sr_ff[DW-1]) ^ output_invert_select[i];
      end
    end
  end
  assign dac_data = dac_data_ff;
endmodule // mcdac_top
`default_nettype wire

// *** dv/mcdac_checker.sv ***
// checker: port assertions for the clock and dac output block
`timescale 1ns/1ps
`default_nettype none
module mcdac_checker #(parameter int NCHAN = 8) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [NCHAN-1:0]   motor_activate,
  input wire logic [NCHAN-1:0]   commutation_select,
  input wire logic [NCHAN*4-1:0] encoder_decode_select,
  input wire logic [NCHAN*2-1:0] output_mode_select,
  input wire logic [NCHAN*2-1:0] target_kind_select,
  input wire logic [23:0]        strobe_word_low_group,
  input wire logic [23:0]        strobe_word_high_group,
  input wire logic               phase_tick,
  input wire logic               top_phase_clock,
  input wire logic               pwm_cycle_tick,
  input wire logic               servo_tick,
  input wire logic [NCHAN-1:0]   motor_run,
  input wire logic [NCHAN-1:0]   single_output,
  input wire logic [NCHAN*20-1:0] command_output_target,
  input wire logic [NCHAN-1:0]   quad_x4,
  input wire logic [NCHAN-1:0]   count_reverse,
  input wire logic [NCHAN-1:0]   ab_dac_mode,
  input wire logic [NCHAN-1:0]   c_pwm_mode,
  input wire logic [NCHAN-1:0]   c_pfm_mode,
  input wire logic [1:0]         dac_bit_tick,
  input wire logic [1:0]         dac_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_servo_runs_motors: assert property (motor_run == (servo_tick ? $past(motor_activate) : '0))
    else $error("motor run not tied to servo tick");
  a_single_output: assert property (single_output == (motor_activate & ~commutation_select))
    else $error("single output wrong");
  a_x4_decode: assert property (quad_x4[0] == (encoder_decode_select[3:0] inside {4'h3, 4'h7})
    && (!quad_x4[0] || count_reverse[0] == (encoder_decode_select[3:0] == 4'h7))) else $error("decode");
  a_output_modes: assert property (ab_dac_mode[0] == output_mode_select[0]
    && c_pwm_mode[0] == (output_mode_select[1:0] == 2'h1)
    && c_pfm_mode[0] == (output_mode_select[1:0] == 2'h3)) else $error("output mode wrong");
  a_servo_on_phase: assert property (servo_tick |-> phase_tick)
    else $error("servo tick off phase");
  a_strobe_msb_first: assert property (phase_tick |=> dac_strobe ==
    {$past(strobe_word_high_group[23], 2), $past(strobe_word_low_group[23], 2)})
    else $error("strobe msb");
  a_strobe_paced: assert property ($changed(dac_strobe[0]) |->
    $past(dac_bit_tick[0], 2) || $past(phase_tick))
    else $error("strobe moved off dac clock");
  a_pwm_top_edge: assert property ($rose(top_phase_clock) == $past(pwm_cycle_tick))
    else $error("pwm tick off top edge");
  a_default_target: assert property (!$past(rst) && $past(target_kind_select[1:0]) == 2'h0
    |-> command_output_target[19:0] == 20'h0c002) else $error("default target wrong");
  a_phase_pulse: assert property (phase_tick |=> !phase_tick)
    else $error("phase tick too long");
endmodule // mcdac_checker
bind mcdac_top mcdac_checker #(.NCHAN(NCHAN)) u_mcdac_checker (.*);
`default_nettype wire

// *** dv/mcdac_dac_model.sv ***
// partner: serial dac pair per group, receives the strobe word
`timescale 1ns/1ps
`default_nettype none
module mcdac_dac_model (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        phase_tick,
  input wire logic [1:0]  dac_bit_tick,
  input wire logic [1:0]  dac_strobe,
  output logic [1:0][23:0] rx
);
  logic [1:0]      tick_d;
  logic [1:0][23:0] sh;
  logic [4:0]      cnt [2];
  // bits are taken the cycle after a clock tick, once the shift has landed
  always @(posedge clk) begin
    tick_d <= dac_bit_tick;
    for (int g = 0; g < 2; g++) begin
      if (rst) begin
        cnt[g] <= 5'h18;
      end else if (phase_tick) begin
        cnt[g] <= 5'h00;
      end else if (tick_d[g] && cnt[g] < 5'h18) begin
        sh[g] <= {sh[g][22:0], dac_strobe[g]};
        cnt[g] <= cnt[g] + 5'h01;
        if (cnt[g] == 5'h17)
          rx[g] <= {sh[g][22:0], dac_strobe[g]};
      end
    end
  end
endmodule // mcdac_dac_model
`default_nettype wire

// *** dv/mcdac_top_bench.sv ***
// testbench: clock chain, strobe, channel setup and command path
`timescale 1ns/1ps
`default_nettype none
module mcdac_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] top_phase_divider = 16'h003f;
  logic [3:0] phase_divider = 4'h1, servo_divider = 4'h2;
  logic [1:0][11:0] hw = {12'h651, 12'h000};
  logic [1:0][23:0] sw = {24'ha5c3e1, 24'h7fffc0};
  logic [31:0] encoder_decode_select = 32'h73737373;
  logic [15:0] output_mode_select = 16'h5555, target_kind_select = 16'h0000;
  logic [7:0] output_invert_select = 8'h20, motor_activate = 8'h5a, commutation_select = 8'h0f;
  logic cmd_valid = 1'b0, cmd_ready, top_phase_clock, phase_tick, servo_tick;
  logic [2:0] cmd_chan = 3'h0;
  logic [15:0] cmd_value = 16'h0000;
  logic [7:0] single_output, quad_x4, count_reverse, ab_dac_mode, c_pwm_mode, c_pfm_mode, dac_data;
  logic [159:0] command_output_target;
  logic [1:0] enc_sample_tick, pulse_freq_mod_clock, dac_bit_tick, adc_tick, dac_strobe;
  logic [1:0][23:0] rx;
  int errors = 0, n_checks = 0;
  always #4 clk = ~clk;
  mcdac_top u_mcdac_top (.clk, .rst, .top_phase_divider, .phase_divider, .servo_divider,
    .hw_clock_select_low_group(hw[0]), .hw_clock_select_high_group(hw[1]),
    .strobe_word_low_group(sw[0]), .strobe_word_high_group(sw[1]), .encoder_decode_select,
    .output_mode_select, .output_invert_select, .motor_activate, .commutation_select,
    .target_kind_select, .cmd_valid, .cmd_ready, .cmd_chan, .cmd_value, .top_phase_clock,
    .pwm_cycle_tick(), .phase_tick, .servo_tick, .motor_run(), .single_output,
    .command_output_target, .quad_x4, .count_reverse, .ab_dac_mode, .c_pwm_mode, .c_pfm_mode,
    .enc_sample_tick, .pulse_freq_mod_clock, .dac_bit_tick, .adc_tick, .dac_strobe, .dac_data);
  mcdac_dac_model u_mcdac_dac_model (.clk, .rst, .phase_tick, .dac_bit_tick, .dac_strobe, .rx);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // counts over a window; the rate generators jitter by one tick, hence the slack
  task automatic t_clocks();
    real e [11];
    int c [11];
    logic tp;
    logic [3:0] t;
    c = '{default: 0};
    e[0] = 8192.0 * 0.9437184 / (2 * (top_phase_divider + 1));
    e[1] = e[0] / (phase_divider + 1);
    e[2] = e[1] / (servo_divider + 1);
    for (int i = 3; i < 11; i++)
      e[i] = 8192.0 * 0.3145728 / (1 << hw[(i-3)/4][((i-3)%4)*3 +: 3]);
    tp = top_phase_clock;
    repeat (8192) begin
      @(posedge clk);
      #1;
      c[0] += (top_phase_clock && !tp);
      tp = top_phase_clock;
      c[1] += phase_tick;
      c[2] += servo_tick;
      for (int g = 0; g < 2; g++) begin
        t = {enc_sample_tick[g], pulse_freq_mod_clock[g], dac_bit_tick[g], adc_tick[g]};
        for (int k = 0; k < 4; k++)
          c[3+g*4+k] += t[3-k];
      end
    end
    for (int i = 0; i < 11; i++) begin
      n_checks++;
      if (c[i] < e[i] - 1.5 || c[i] > e[i] + 1.5) begin
        errors++;
        $display("mismatch tick count %0d expected %f seen %0d", i, e[i], c[i]);
      end
    end
    $display("clock rates done");
  endtask
  task automatic t_strobe();
    repeat (2) @(posedge clk iff phase_tick);
    chk("strobe low", 24'h7fffc0, rx[0]);
    chk("strobe high", 24'ha5c3e1, rx[1]);
    $display("strobe words done");
  endtask
  task automatic t_modes();
    for (int d = 0; d < 16; d++) begin
      @(negedge clk);
      encoder_decode_select[11:8] = d[3:0];
      #1;
      chk("quad x4", d == 3 || d == 7, quad_x4[2]);
      if (d == 3 || d == 7)
        chk("count reverse", d == 7, count_reverse[2]);
    end
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      output_mode_select[5:4] = m[1:0];
      #1;
      chk("ab dac", m[0], ab_dac_mode[2]);
      chk("c pwm", m == 1, c_pwm_mode[2]);
      chk("c pfm", m == 3, c_pfm_mode[2]);
    end
    chk("single output", motor_activate & ~commutation_select, single_output);
    $display("channel modes done");
  endtask
  task automatic t_target();
    logic [19:0] a;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      target_kind_select = {8{k[1:0]}};
      repeat (2) @(posedge clk);
      #1;
      for (int m = 0; m < 8; m++) begin
        case (k)
          1: a = 20'h0c0a3 + 4 * (m % 2) + 8 * (m / 4) + ((m / 2) % 2 ? 20'h80000 : 20'h0);
          3: a = 20'h0c0a0 + 4 * m;
          default: a = 20'h0c002 + 8 * m;
        endcase
        chk("target", a, command_output_target[m*20 +: 20]);
      end
    end
    $display("command targets done");
  endtask
  // one word, read back bit by bit on the group's dac clock
  task automatic t_send(logic [2:0] ch, logic [15:0] v);
    logic [15:0] w;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_chan = ch;
    cmd_value = v;
    @(posedge clk iff cmd_ready);
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk iff dac_bit_tick[ch[2]]);
      @(posedge clk);
      #1;
      w[i] = dac_data[ch];
    end
    chk("dac word", v ^ {16{output_invert_select[ch]}}, w);
    $display("dac word done");
  endtask
  task automatic t_fifo();
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_chan = 3'h1;
    cmd_value = 16'h8001;
    while (cmd_ready && n < 40) begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end
    cmd_valid = 1'b0;
    chk("fifo fill", 1, n >= 16 && n <= 18);
    repeat (2000) @(posedge clk);
    $display("fifo fill done");
    t_send(3'h1, 16'h4b2d);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(posedge clk iff phase_tick);
    t_clocks();
    t_strobe();
    t_modes();
    t_target();
    t_send(3'h0, 16'hc35a);
    t_send(3'h5, 16'h1e87);
    t_fifo();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("mismatch watchdog expected done seen hang");
    final_report();
  end
endmodule // mcdac_top_bench
`default_nettype wire
